/* File: ebd_pkg.sv */
// shared constants for the external data and read strobe pin block
package ebd_pkg;
  localparam int          EBD_DATA_W       = 16;
  localparam int          EBD_SHARED_W     = 9;
  localparam int          EBD_SHARED_LO    = 7;
  localparam int          EBD_ADDR_W       = 17;
  localparam int          EBD_CS_W         = 4;
  localparam logic [8:0]  EBD_SEL_RST      = 9'h000;
  localparam logic [8:0]  EBD_PULLUP_RST   = 9'h1FF;
  localparam logic        EBD_DRIVE_RST    = 1'b0;
  localparam int          EBD_RD_CYCLES    = 2;
  localparam logic [1:0]  EBD_RD_CNT_W1    = 2'h1;
  localparam int          EBD_SYNC_STAGES  = 2;
endpackage

/* File: ebd_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module ebd_sync #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule // ebd_sync

/* File: ebd_pins.sv */
// external data bus upper lines, port f sharing and read strobe
//
// Overview of operation
// R01 - shared pins carry external data bits seven to fifteen during accesses
// R02 - in port mode each shared pin and bit fifteen pin is input or output
// R03 - after reset every shared pin takes the external bus function
// R04 - clearing pull-up enable bit n switches off line n pull-up
// R05 - read strobe low on each read; all sixteen data pins are inputs then (port-mode output pins stay driven)
// R06 - data bus value captured as the read strobe returns high
// R07 - address, selects and chip selects held valid while strobe is low
// R08 - idle strobe floats or stays driven per bus drive bit
// R09 - software should set the bus drive bit to one
// R10 - memory drives the bus only while the read strobe is low
// R11 - per-pin select bit picks bus or port function; reset picks bus
// R12 - in reset data and strobe drivers off, pull-ups on
`timescale 1ns/10ps
module ebd_pins (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        rd_req,
  input  wire logic [16:0] rd_addr,
  input  wire logic        rd_prog,
  input  wire logic [3:0]  rd_cs,
  input  wire logic        bus_drive_keep,
  input  wire logic [8:0]  port_f_select,
  input  wire logic [8:0]  port_f_dir,
  input  wire logic [8:0]  port_f_out,
  input  wire logic [8:0]  port_f_pullup_enable,
  input  wire logic [15:0] data_pin_in,
  output logic      [15:0] data_pin_out,
  output logic      [15:0] data_pin_oe,
  output logic      [8:0]  pullup_en,
  output logic      [8:0]  port_f_line_in,
  output logic             rd_strobe_n_out,
  output logic             rd_strobe_n_oe,
  output logic      [16:0] ext_address_lines,
  output logic             program_select_n,
  output logic             data_select_n,
  output logic      [3:0]  chip_select_n,
  output logic      [15:0] rd_data,
  output logic             rd_done,
  output logic             rd_busy
);
  logic [15:0] data_sync;
  logic [1:0]  cnt_reg;
  logic [1:0]  cnt_next;
  logic        strobe_low;
  logic        finish;
  logic [15:0] oe_next;
  logic [15:0] out_next;
  logic [8:0]  port_sel_reg;
  logic        capture_reg;

  ebd_sync #(.W(ebd_pkg::EBD_DATA_W)) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in (data_pin_in),
    .sync_out (data_sync)
  );

  assign strobe_low = rd_busy;
  assign finish     = strobe_low && (cnt_reg == 2'h0);
  assign cnt_next   = finish ? 2'h0 :
                      strobe_low ? cnt_reg - 2'h1 :
                      (rd_req ? ebd_pkg::EBD_RD_CNT_W1 : 2'h0);

  // R03 R11 bus after reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_sel_reg <= ebd_pkg::EBD_SEL_RST;
    end else begin
      port_sel_reg <= port_f_select;
    end
  end

  // R02 R11 per-pin direction mux
  genvar g;
  generate
    for (g = 0; g < ebd_pkg::EBD_DATA_W; g++) begin : g_pin
      if (g >= ebd_pkg::EBD_SHARED_LO) begin : g_sh
        localparam int K = g - ebd_pkg::EBD_SHARED_LO;
        // R05 inputs during read
        assign oe_next[g]  = port_sel_reg[K] ? port_f_dir[K] : 1'b0;
        assign out_next[g] = port_sel_reg[K] ? port_f_out[K] : 1'b0;
      end else begin : g_bus
        assign oe_next[g]  = 1'b0;
        assign out_next[g] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // R12 drivers off, pull-ups on
      data_pin_out    <= 16'h0000;
      data_pin_oe     <= 16'h0000;
      pullup_en       <= ebd_pkg::EBD_PULLUP_RST;
      rd_strobe_n_out <= 1'b1;
      rd_strobe_n_oe  <= 1'b0;
      rd_busy         <= 1'b0;
      cnt_reg         <= 2'h0;
    end else begin
      data_pin_out    <= out_next;
      data_pin_oe     <= oe_next;
      // R04 pull-up gating
      pullup_en       <= port_f_pullup_enable;
      cnt_reg         <= cnt_next;
      // R05 strobe low
      rd_busy         <= finish ? 1'b0 : (rd_busy | rd_req);
      rd_strobe_n_out <= finish ? 1'b1 : !(rd_busy | rd_req);
      // R08 idle drive choice
      rd_strobe_n_oe  <= (rd_busy | rd_req) & !finish ? 1'b1 : bus_drive_keep;
    end
  end

  // R07 hold qualifiers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_address_lines <= 17'h00000;
      program_select_n  <= 1'b1;
      data_select_n     <= 1'b1;
      chip_select_n     <= 4'hF;
    end else if (!rd_busy) begin
      ext_address_lines <= rd_addr;
      program_select_n  <= !(rd_req && rd_prog);
      data_select_n     <= !(rd_req && !rd_prog);
      chip_select_n     <= rd_req ? ~rd_cs : 4'hF;
    end
  end

  // R01 R06 capture on strobe rise
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data        <= 16'h0000;
      rd_done        <= 1'b0;
      capture_reg    <= 1'b0;
      port_f_line_in <= 9'h000;
    end else begin
      // synchronised pins lag, so latch one edge after the rise
      capture_reg    <= finish;
      rd_done        <= capture_reg;
      port_f_line_in <= data_sync[15:7];
      if (capture_reg) begin
        rd_data <= data_sync;
      end
    end
  end

  // R05 strobe low while busy
  property p_strobe_busy;
    @(posedge sys_clk) disable iff (!rst_b)
      rd_busy |-> (!rd_strobe_n_out && rd_strobe_n_oe);
  endproperty
  a_strobe_busy: assert property (p_strobe_busy) else $error("strobe not low in read"); // R05

  // R05 data pins released
  property p_inputs;
    @(posedge sys_clk) disable iff (!rst_b)
      rd_busy |-> (data_pin_oe & ~$past({port_sel_reg & port_f_dir, 7'h00})) == 16'h0000;
  endproperty
  a_inputs: assert property (p_inputs) else $error("bus pin driven in read"); // R05

  // R06 capture at rise
  property p_capture;
    @(posedge sys_clk) disable iff (!rst_b)
      $rose(rd_strobe_n_out) |=> rd_done && rd_data == $past(data_pin_in, 3);
  endproperty
  a_capture: assert property (p_capture) else $error("data not captured"); // R06

  // R07 address stable
  property p_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      (rd_busy && $past(rd_busy)) |-> $stable(ext_address_lines) && $stable(chip_select_n);
  endproperty
  a_hold: assert property (p_hold) else $error("qualifiers moved in read"); // R07

  // R08 idle drive
  property p_idle;
    @(posedge sys_clk) disable iff (!rst_b)
      (!rd_busy && !$past(rd_req)) |-> rd_strobe_n_oe == $past(bus_drive_keep);
  endproperty
  a_idle: assert property (p_idle) else $error("idle strobe drive wrong"); // R08

  // R04 pull-up follows enable
  property p_pullup;
    @(posedge sys_clk) disable iff (!rst_b)
      1'b1 |=> pullup_en == $past(port_f_pullup_enable);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up mismatch"); // R04

  // R02 port output drive
  property p_port;
    @(posedge sys_clk) disable iff (!rst_b)
      (port_sel_reg[8] && port_f_dir[8]) |=>
        data_pin_oe[15] && data_pin_out[15] == $past(port_f_out[8]);
  endproperty
  a_port: assert property (p_port) else $error("port line not driven"); // R02

  // R05 strobe length
  sequence s_start;
    $fell(rd_strobe_n_out);
  endsequence
  property p_len;
    @(posedge sys_clk) disable iff (!rst_b)
      s_start |-> !rd_strobe_n_out [*2] ##1 rd_strobe_n_out;
  endproperty
  a_len: assert property (p_len) else $error("strobe length wrong"); // R05

  // R07 one select per read
  property p_select;
    @(posedge sys_clk) disable iff (!rst_b)
      s_start |-> (program_select_n ^ data_select_n) [*2];
  endproperty
  a_select: assert property (p_select) else $error("select wrong in read"); // R07

  // R06 done is one pulse
  property p_done;
    @(posedge sys_clk) disable iff (!rst_b)
      rd_done |=> !rd_done;
  endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle"); // R06

  // R03 bus pins undriven
  property p_bus_idle;
    @(posedge sys_clk) disable iff (!rst_b)
      (port_sel_reg == 9'h000) |=> data_pin_oe == 16'h0000;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("bus pin driven"); // R03
endmodule // ebd_pins

/* File: ebd_mem.sv */
// external memory model answering reads
`timescale 1ns/10ps
module ebd_mem (
  input  wire logic        strobe_n,
  input  wire logic        strobe_oe,
  input  wire logic [16:0] addr,
  output logic      [15:0] data
);
  assign data = (strobe_oe && !strobe_n) ? (addr[15:0] ^ 16'hA5C3) : 16'hFFFF;
endmodule // ebd_mem

/* File: ebd_pins_tb.sv */
// self-checking bench for the data pin block
`timescale 1ns/10ps
module ebd_pins_tb;
  logic        sys_clk, rd_done, rd_busy, rd_strobe_n_out, rd_strobe_n_oe;
  logic        rst_b = 1'b0, rd_req = 1'b0, rd_prog = 1'b0, bus_drive_keep = 1'b0;
  logic        program_select_n, data_select_n;
  logic [16:0] rd_addr = 17'h0, ext_address_lines;
  logic [3:0]  rd_cs = 4'h0, chip_select_n;
  logic [8:0]  port_f_select = 9'h0, port_f_dir = 9'h0, port_f_out = 9'h0;
  logic [8:0]  port_f_pullup_enable = 9'h1FF, pullup_en, port_f_line_in;
  logic [15:0] data_pin_in, data_pin_out, data_pin_oe, rd_data, mem_data;
  logic [15:0] q[$];
  int          fail_count = 0;
  int          compares = 0;

  assign data_pin_in = (data_pin_oe & data_pin_out) | (~data_pin_oe & mem_data);
  ebd_pins DUT (.sys_clk, .rst_b, .rd_req, .rd_addr, .rd_prog, .rd_cs, .bus_drive_keep,
    .port_f_select, .port_f_dir, .port_f_out, .port_f_pullup_enable, .data_pin_in,
    .data_pin_out, .data_pin_oe, .pullup_en, .port_f_line_in, .rd_strobe_n_out,
    .rd_strobe_n_oe, .ext_address_lines, .program_select_n, .data_select_n,
    .chip_select_n, .rd_data, .rd_done, .rd_busy);
  ebd_mem mem (.strobe_n(rd_strobe_n_out), .strobe_oe(rd_strobe_n_oe),
    .addr(ext_address_lines), .data(mem_data));

  task chk(input string n, input logic [16:0] e, input logic [16:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task rd(input logic [16:0] a, input logic p, input logic [3:0] cs);
    int n;
    @(negedge sys_clk);
    rd_req = 1'b1;
    rd_addr = a;
    rd_prog = p;
    rd_cs = cs;
    q.push_back(a[15:0] ^ 16'hA5C3);
    @(negedge sys_clk);
    rd_req = 1'b0;
    chk("strobe", 17'h1, {rd_strobe_n_out, rd_strobe_n_oe});
    chk("data_oe", 17'h0, data_pin_oe);
    chk("addr", a, ext_address_lines);
    chk("sel", {~p, p, ~cs}, {program_select_n, data_select_n, chip_select_n});
    n = 0;
    while (rd_busy === 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk("rd_len", 17'(ebd_pkg::EBD_RD_CYCLES), 17'(n));
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    #1;
    if (rd_done === 1'b1) begin
      if (q.size() == 0) chk("extra_done", 17'h0, 17'h1);
      else chk("rd_data", q.pop_front(), rd_data);
    end
  end

  initial begin
    #100000;
    fail_count++;
    results;
  end

  initial begin
    void'($urandom(42762));
    repeat (4) @(negedge sys_clk);
    chk("rst_oe", 17'h0, {data_pin_oe, rd_strobe_n_oe});
    chk("rst_pu", 17'h1FF, pullup_en);
    rst_b = 1'b1;
    for (int i = 0; i < 6; i++) rd(17'($urandom), i[0], 4'h1 << i[1:0]);
    repeat (2) @(negedge sys_clk);
    chk("idle_oe0", 17'h0, rd_strobe_n_oe);
    bus_drive_keep = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("idle_oe1", 17'h1, rd_strobe_n_oe);
    port_f_pullup_enable = 9'($urandom);
    repeat (2) @(negedge sys_clk);
    chk("pullup", port_f_pullup_enable, pullup_en);
    port_f_select = 9'h1FF;
    port_f_dir = 9'($urandom);
    port_f_out = 9'($urandom);
    repeat (5) @(negedge sys_clk);
    chk("pf_oe", port_f_dir, data_pin_oe[15:7]);
    chk("pf_out", {port_f_dir & port_f_out}, {data_pin_out[15:7] & port_f_dir});
    chk("pf_in", {port_f_out | ~port_f_dir}, port_f_line_in);
    chk("q_left", 17'h0, 17'(q.size()));
    rst_b = 1'b0;
    #1;
    chk("rst2_oe", 17'h0, {data_pin_oe, rd_strobe_n_oe});
    chk("rst2_pu", 17'h1FF, pullup_en);
    results;
  end
endmodule // ebd_pins_tb
